// >>> verilog/adccc_pkg.sv
// Shared constants for the converter control block
package adccc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_CONTROL = 6'h20;
   localparam logic [5:0] IDX_MODE = 6'h21;
   localparam logic [5:0] IDX_RESULT_HIGH = 6'h22;
   localparam logic [5:0] IDX_RESULT_LOW = 6'h23;
   localparam logic [5:0] IDX_IRQ_STATUS = 6'h24;
   localparam logic [5:0] IDX_IRQ_MASK = 6'h25;

   ////////////////////////////////////////////////////////////////////////////
   // Control register fields
   localparam int CTL_ENABLE_BIT = 7;
   localparam int CTL_PROCESS_BIT = 6;
   localparam int CTL_CHAN_LSB = 2;
   localparam int CTL_CHAN_W = 4;
   localparam logic CTL_ENABLE_RST = 1'b0;
   localparam logic [3:0] CTL_CHAN_RST = 4'h0;
   localparam logic CTL_DONE_RST = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Mode register fields
   localparam int MODE_RES_LSB = 5;
   localparam int MODE_RES_W = 3;
   localparam int MODE_CLK_LSB = 1;
   localparam int MODE_CLK_W = 3;
   localparam logic [2:0] MODE_RES_RST = 3'h0;
   localparam logic [2:0] MODE_CLK_RST = 3'h0;
   localparam logic [2:0] RES_12BIT = 3'h4;

   ////////////////////////////////////////////////////////////////////////////
   // Channel codes
   localparam logic [3:0] CH_PORT_B_LAST = 4'h7;
   localparam logic [3:0] CH_PORT_A_PIN_THREE = 4'h8;
   localparam logic [3:0] CH_PORT_A_PIN_FOUR = 4'h9;
   localparam logic [3:0] CH_BANDGAP = 4'hf;

   ////////////////////////////////////////////////////////////////////////////
   // Result layout and interrupt bits
   localparam int RESULT_W = 12;
   localparam int RES_LOW_NIBBLE_LSB = 4;
   localparam int IRQ_W = 2;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_REFUSED_BIT = 1;
   localparam logic [1:0] IRQ_RST = 2'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Timing and divider
   localparam int SAMPLE_TICKS = 4;
   localparam int DIV_W = 7;

   typedef enum logic [2:0] {
      ADCCC_IDLE = 3'b001,
      ADCCC_SAMPLE = 3'b010,
      ADCCC_CONVERT = 3'b100
   } adccc_state_t;

endpackage

// >>> verilog/adccc_top.sv
// Converter control: registers, clock divider, channel mux and SAR sequencing
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module adccc_top #(
   parameter int SAMPLE_TICKS = adccc_pkg::SAMPLE_TICKS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [7:0] port_b_sel_o,
   output logic port_a_pin_three_sel_o,
   output logic port_a_pin_four_sel_o,
   output logic bandgap_sel_o,
   output logic sample_o,
   output logic [11:0] dac_code_o,
   input wire logic cmp_i,
   output logic busy_o,
   output logic irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   // One-hot mask for a result bit position
   function automatic logic [11:0] bit_mask(input logic [3:0] idx);
      bit_mask = 12'h001 << idx;
   endfunction

   // Divider mask: all ones below the chosen power of two
   function automatic logic [6:0] div_mask(input logic [2:0] sel);
      div_mask = 7'(({7'h00, 1'b1} << sel) - 8'h01);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic enable_ff;
   logic start_req_ff;
   logic done_ff;
   logic [3:0] chan_ff;
   logic [2:0] res_mode_ff;
   logic [2:0] clk_sel_ff;
   logic [11:0] result_ff;
   logic [11:0] code_ff;
   logic [3:0] bit_idx_ff;
   logic [7:0] sample_cnt_ff;
   logic [6:0] div_cnt_ff;
   logic [1:0] irq_status_ff;
   logic [1:0] irq_mask_ff;
   logic ack_ff;
   logic [31:0] rdata_ff;
   adccc_pkg::adccc_state_t state_ff;
   adccc_pkg::adccc_state_t nxt_state;

   logic bus_req;
   logic wr_lane0;
   logic [5:0] reg_idx;
   logic wr_control;
   logic wr_mode;
   logic wr_irq_status;
   logic wr_irq_mask;
   logic conv_tick;
   logic chan_legal;
   logic start_go;
   logic start_refused;
   logic final_bit;
   logic conv_done;
   logic [11:0] final_code;
   logic [1:0] irq_events;

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone classic slave

   // Access taken in the first cycle of stb; ack follows one cycle later
   assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
   assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];
   assign reg_idx = wb_adr_i[7:2];
   assign wr_control = wr_lane0 && (reg_idx == adccc_pkg::IDX_CONTROL);
   assign wr_mode = wr_lane0 && (reg_idx == adccc_pkg::IDX_MODE);
   assign wr_irq_status = wr_lane0 && (reg_idx == adccc_pkg::IDX_IRQ_STATUS);
   assign wr_irq_mask = wr_lane0 && (reg_idx == adccc_pkg::IDX_IRQ_MASK);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= bus_req;
      end
   end

   assign wb_ack_o = ack_ff;

   // Read data captured with the request; unmapped and write-only read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_ff <= 32'h0000_0000;
      end else if (bus_req && !wb_we_i) begin
         rdata_ff <= 32'h0000_0000;
         unique case (reg_idx)
            adccc_pkg::IDX_CONTROL: begin
               rdata_ff[adccc_pkg::CTL_ENABLE_BIT] <= enable_ff;
               rdata_ff[adccc_pkg::CTL_PROCESS_BIT] <= done_ff;
               rdata_ff[adccc_pkg::CTL_CHAN_LSB +: adccc_pkg::CTL_CHAN_W] <= chan_ff;
            end
            adccc_pkg::IDX_RESULT_HIGH: begin
               rdata_ff[7:0] <= result_ff[11:4];
            end
            adccc_pkg::IDX_RESULT_LOW: begin
               rdata_ff[7:adccc_pkg::RES_LOW_NIBBLE_LSB] <= result_ff[3:0];
            end
            adccc_pkg::IDX_IRQ_STATUS: begin
               rdata_ff[adccc_pkg::IRQ_W-1:0] <= irq_status_ff;
            end
            adccc_pkg::IDX_IRQ_MASK: begin
               rdata_ff[adccc_pkg::IRQ_W-1:0] <= irq_mask_ff;
            end
            default: begin
               rdata_ff <= 32'h0000_0000;
            end
         endcase
      end
   end

   assign wb_dat_o = rdata_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Control register

   // Reserved bits 1..0 are dropped on write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable_ff <= adccc_pkg::CTL_ENABLE_RST;
         chan_ff <= adccc_pkg::CTL_CHAN_RST;
      end else if (wr_control) begin
         enable_ff <= wb_dat_i[adccc_pkg::CTL_ENABLE_BIT];
         chan_ff <= wb_dat_i[adccc_pkg::CTL_CHAN_LSB +: adccc_pkg::CTL_CHAN_W];
      end
   end

   // Software set wins over the self-clear of the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_req_ff <= 1'b0;
      end else if (wr_control && wb_dat_i[adccc_pkg::CTL_PROCESS_BIT]) begin
         start_req_ff <= 1'b1;
      end else if (start_go || start_refused) begin
         start_req_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode register, write-only

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         res_mode_ff <= adccc_pkg::MODE_RES_RST;
         clk_sel_ff <= adccc_pkg::MODE_CLK_RST;
      end else if (wr_mode) begin
         res_mode_ff <= wb_dat_i[adccc_pkg::MODE_RES_LSB +: adccc_pkg::MODE_RES_W];
         clk_sel_ff <= wb_dat_i[adccc_pkg::MODE_CLK_LSB +: adccc_pkg::MODE_CLK_W];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Conversion clock divider

   // Free running so the tick phase never depends on the start write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_cnt_ff <= 7'h00;
      end else begin
         div_cnt_ff <= div_cnt_ff + 7'h01;
      end
   end

   assign conv_tick = ((div_cnt_ff & div_mask(clk_sel_ff)) == div_mask(clk_sel_ff));

   ////////////////////////////////////////////////////////////////////////////
   // Channel routing

   assign chan_legal = (chan_ff <= adccc_pkg::CH_PORT_A_PIN_FOUR)
                    || (chan_ff == adccc_pkg::CH_BANDGAP);

   // Reserved codes connect nothing
   always_comb begin
      port_b_sel_o = 8'h00;
      if (chan_ff <= adccc_pkg::CH_PORT_B_LAST) begin
         port_b_sel_o = 8'(9'h001 << chan_ff[2:0]);
      end
   end

   assign port_a_pin_three_sel_o = (chan_ff == adccc_pkg::CH_PORT_A_PIN_THREE);
   assign port_a_pin_four_sel_o = (chan_ff == adccc_pkg::CH_PORT_A_PIN_FOUR);
   assign bandgap_sel_o = (chan_ff == adccc_pkg::CH_BANDGAP);

   ////////////////////////////////////////////////////////////////////////////
   // Start decision

   // Only a legal channel and the 12-bit resolution may convert
   assign start_go = (state_ff == adccc_pkg::ADCCC_IDLE) && start_req_ff && enable_ff
                  && chan_legal && (res_mode_ff == adccc_pkg::RES_12BIT);
   assign start_refused = (state_ff == adccc_pkg::ADCCC_IDLE) && start_req_ff
                       && !start_go;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer

   assign final_bit = (bit_idx_ff == 4'h0);
   assign conv_done = (state_ff == adccc_pkg::ADCCC_CONVERT) && conv_tick && final_bit;
   assign final_code = cmp_i ? code_ff : (code_ff & ~bit_mask(bit_idx_ff));

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         adccc_pkg::ADCCC_IDLE: begin
            if (start_go) begin
               nxt_state = adccc_pkg::ADCCC_SAMPLE;
            end
         end
         adccc_pkg::ADCCC_SAMPLE: begin
            if (!enable_ff) begin
               nxt_state = adccc_pkg::ADCCC_IDLE;
            end else if (conv_tick && (sample_cnt_ff == 8'(SAMPLE_TICKS - 1))) begin
               nxt_state = adccc_pkg::ADCCC_CONVERT;
            end
         end
         adccc_pkg::ADCCC_CONVERT: begin
            if (!enable_ff || conv_done) begin
               nxt_state = adccc_pkg::ADCCC_IDLE;
            end
         end
         default: begin
            nxt_state = adccc_pkg::ADCCC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= adccc_pkg::ADCCC_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Sampling period in conversion clock ticks
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sample_cnt_ff <= 8'h00;
      end else if (state_ff != adccc_pkg::ADCCC_SAMPLE) begin
         sample_cnt_ff <= 8'h00;
      end else if (conv_tick) begin
         sample_cnt_ff <= sample_cnt_ff + 8'h01;
      end
   end

   // Successive approximation from the top bit down
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         code_ff <= 12'h000;
         bit_idx_ff <= 4'h0;
      end else if (state_ff == adccc_pkg::ADCCC_SAMPLE) begin
         code_ff <= bit_mask(4'hb);
         bit_idx_ff <= 4'hb;
      end else if ((state_ff == adccc_pkg::ADCCC_CONVERT) && conv_tick && !final_bit) begin
         code_ff <= final_code | bit_mask(bit_idx_ff - 4'h1);
         bit_idx_ff <= bit_idx_ff - 4'h1;
      end
   end

   // Result and done change in one edge so no torn read is possible
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result_ff <= 12'h000;
         done_ff <= adccc_pkg::CTL_DONE_RST;
      end else if (conv_done && enable_ff) begin
         result_ff <= final_code;
         done_ff <= 1'b1;
      end else if (start_go) begin
         done_ff <= 1'b0;
      end
   end

   assign sample_o = (state_ff == adccc_pkg::ADCCC_SAMPLE);
   assign dac_code_o = code_ff;
   assign busy_o = (state_ff != adccc_pkg::ADCCC_IDLE);

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts

   always_comb begin
      irq_events = 2'h0;
      irq_events[adccc_pkg::IRQ_DONE_BIT] = conv_done && enable_ff;
      irq_events[adccc_pkg::IRQ_REFUSED_BIT] = start_refused;
   end

   // Write one clears; a new event in the same cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status_ff <= adccc_pkg::IRQ_RST;
      end else if (wr_irq_status) begin
         irq_status_ff <= (irq_status_ff & ~wb_dat_i[adccc_pkg::IRQ_W-1:0]) | irq_events;
      end else begin
         irq_status_ff <= irq_status_ff | irq_events;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_ff <= adccc_pkg::IRQ_RST;
      end else if (wr_irq_mask) begin
         irq_mask_ff <= wb_dat_i[adccc_pkg::IRQ_W-1:0];
      end
   end

   assign irq_o = |(irq_status_ff & irq_mask_ff);

endmodule // adccc_top

`default_nettype wire

// >>> test/adccc_monitor.sv
// Port checks on the converter control top
`timescale 1ns/1ps
`default_nettype none
module adccc_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [7:0] port_b_sel_o,
   input wire logic port_a_pin_three_sel_o,
   input wire logic port_a_pin_four_sel_o,
   input wire logic bandgap_sel_o,
   input wire logic sample_o,
   input wire logic [11:0] dac_code_o,
   input wire logic cmp_i,
   input wire logic busy_o,
   input wire logic irq_o
);
   logic ctl_wr;
   assign ctl_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
      && wb_adr_i == 8'h80;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////
   a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged next cycle");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_sel_onehot: assert property (
      $onehot0({bandgap_sel_o, port_a_pin_four_sel_o, port_a_pin_three_sel_o, port_b_sel_o}))
      else $error("more than one input routed");
   a_sel_bandgap: assert property (ctl_wr && wb_dat_i[5:2] == 4'hf |=> bandgap_sel_o)
      else $error("reference not routed");
   a_sel_pin_four: assert property (
      ctl_wr && wb_dat_i[5:2] == 4'h9 |=> port_a_pin_four_sel_o && port_b_sel_o == 8'h00)
      else $error("port a pin four not routed");
   a_sample_busy: assert property (sample_o |-> busy_o)
      else $error("sampling while not busy");
   a_reset_idle: assert property (
      disable iff (1'b0) rst_i |=> !busy_o && !irq_o && port_b_sel_o == 8'h01)
      else $error("not idle after reset");
   a_off_abort: assert property (ctl_wr && !wb_dat_i[7] |-> ##3 !busy_o)
      else $error("busy after converter disabled");
   a_trial_top: assert property (sample_o && $past(sample_o) |-> dac_code_o == 12'h800)
      else $error("trial code not at top bit while sampling");
endmodule // adccc_monitor
bind adccc_top adccc_monitor u_mon (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_b_sel_o(port_b_sel_o),
   .port_a_pin_three_sel_o(port_a_pin_three_sel_o),
   .port_a_pin_four_sel_o(port_a_pin_four_sel_o), .bandgap_sel_o(bandgap_sel_o),
   .sample_o(sample_o), .dac_code_o(dac_code_o), .cmp_i(cmp_i), .busy_o(busy_o),
   .irq_o(irq_o));
`default_nettype wire

// >>> test/adccc_analog_model.sv
// Analog inputs and comparator seen by the converter
`timescale 1ns/1ps
`default_nettype none
module adccc_analog_model #(
   parameter logic [11:0] LVL_A3 = 12'h8c3,
   parameter logic [11:0] LVL_A4 = 12'h9e7,
   parameter logic [11:0] LVL_BG = 12'h5d1
) (
   input wire logic [7:0] port_b_sel_i,
   input wire logic port_a_pin_three_sel_i,
   input wire logic port_a_pin_four_sel_i,
   input wire logic bandgap_sel_i,
   input wire logic [11:0] dac_code_i,
   output logic cmp_o
);
   logic [11:0] lvl;
   // Nothing routed reads as ground
   // Routed pins have their digital input off, so no leakage is modelled
   always_comb begin
      lvl = 12'h000;
      for (int i = 0; i < 8; i++) begin
         if (port_b_sel_i[i]) lvl = {i[3:0], 8'h3c};
      end
      if (port_a_pin_three_sel_i) lvl = LVL_A3;
      if (port_a_pin_four_sel_i) lvl = LVL_A4;
      if (bandgap_sel_i) lvl = LVL_BG;
      cmp_o = (lvl >= dac_code_i);
   end
endmodule // adccc_analog_model
`default_nettype wire

// >>> test/tb.sv
// Register-level bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [11:0] LVL_A4 = 12'h9e7;
   localparam logic [11:0] LVL_BG = 12'h5d1;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cmp_i, busy_o, irq_o;
   logic a3, a4, bg, sample_o;
   logic [7:0] wb_adr_i, port_b_sel_o;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rdat;
   logic [11:0] dac_code_o, lvl;
   logic [7:0] ctl_tab [3] = '{8'hcc, 8'hfc, 8'he4};
   logic [7:0] bad_mode [3] = '{8'h00, 8'h80, 8'h80};
   logic [7:0] bad_ctl [3] = '{8'hcc, 8'he8, 8'h4c};
   logic [11:0] lvl_tab [3] = '{12'h33c, LVL_BG, LVL_A4};
   int div_tab [3] = '{0, 2, 7};
   int n_mismatch = 0, check_count = 0, cnt = 0, c0;
   adccc_top #(.SAMPLE_TICKS(1)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .port_b_sel_o(port_b_sel_o), .port_a_pin_three_sel_o(a3),
      .port_a_pin_four_sel_o(a4), .bandgap_sel_o(bg), .sample_o(sample_o),
      .dac_code_o(dac_code_o), .cmp_i(cmp_i), .busy_o(busy_o), .irq_o(irq_o));
   adccc_analog_model #(.LVL_A4(LVL_A4), .LVL_BG(LVL_BG)) u_ana (.port_b_sel_i(port_b_sel_o),
      .port_a_pin_three_sel_i(a3), .port_a_pin_four_sel_i(a4), .bandgap_sel_i(bg),
      .dac_code_i(dac_code_o), .cmp_o(cmp_i));
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (busy_o === 1'b1) cnt <= cnt + 1;
   ////////////////////////////////////////
   task automatic tally_and_finish();
      if (n_mismatch == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Classic cycle held until ack is sampled, released at that edge
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= {24'h0, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 40);
      chk("bus ack", {31'h0, wb_ack_o}, 32'h1);
      if (wb_ack_o !== 1'b1) tally_and_finish();
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   function automatic logic [31:0] route_of(input logic [3:0] c);
      if (c < 4'h8) return 32'h1 << c;
      if (c == 4'h8) return 32'h100;
      if (c == 4'h9) return 32'h200;
      return (c == 4'hf) ? 32'h400 : 32'h0;
   endfunction
   ////////////////////////////////////////
   initial begin
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h1;
      wb_dat_i = 32'h0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      acc(1'b0, 8'h80, 8'h00);
      chk("control reset", rdat, 32'h0);
      acc(1'b0, 8'h84, 8'h00);
      chk("mode reads", rdat, 32'h0);
      acc(1'b0, 8'hfc, 8'h00);
      chk("unmapped", rdat, 32'h0);
      for (int c = 0; c < 16; c++) begin
         acc(1'b1, 8'h80, {2'b00, c[3:0], 2'b00});
         chk("route", {21'h0, bg, a4, a3, port_b_sel_o}, route_of(c[3:0]));
      end
      acc(1'b1, 8'h94, 8'h01);
      for (int i = 0; i < 3; i++) begin
         lvl = lvl_tab[i];
         acc(1'b1, 8'h84, {3'h4, 1'b0, div_tab[i][2:0], 1'b0});
         c0 = cnt;
         acc(1'b1, 8'h80, ctl_tab[i]);
         acc(1'b0, 8'h80, 8'h00);
         chk("flag busy", {31'h0, rdat[6]}, 32'h0);
         for (int k = 0; k < 900 && rdat[6] !== 1'b1; k++) acc(1'b0, 8'h80, 8'h00);
         chk("flag done", {31'h0, rdat[6]}, 32'h1);
         if (rdat[6] !== 1'b1) tally_and_finish();
         chk("tick span", {31'h0, cnt - c0 >= (12 << div_tab[i]) &&
            cnt - c0 <= (14 << div_tab[i]) + 2}, 32'h1);
         acc(1'b0, 8'h88, 8'h00);
         chk("result high", rdat, {24'h0, lvl[11:4]});
         acc(1'b0, 8'h8c, 8'h00);
         chk("result low", rdat, {24'h0, lvl[3:0], 4'h0});
         chk("irq done", {31'h0, irq_o}, 32'h1);
         acc(1'b1, 8'h90, 8'h01);
         chk("irq cleared", {31'h0, irq_o}, 32'h0);
      end
      acc(1'b1, 8'h88, 8'hff);
      acc(1'b0, 8'h88, 8'h00);
      chk("high read-only", rdat, {24'h0, LVL_A4[11:4]});
      acc(1'b1, 8'h94, 8'h00);
      for (int i = 0; i < 3; i++) begin
         // Clear the sticky refusal so each pass must raise it anew
         acc(1'b1, 8'h90, 8'h02);
         acc(1'b1, 8'h84, bad_mode[i]);
         c0 = cnt;
         acc(1'b1, 8'h80, bad_ctl[i]);
         acc(1'b0, 8'h90, 8'h00);
         chk("refused", rdat, 32'h2);
         acc(1'b0, 8'h80, 8'h00);
         chk("no start", {30'(cnt - c0), 1'b0, rdat[6]}, 32'h1);
      end
      chk("irq masked", {31'h0, irq_o}, 32'h0);
      acc(1'b1, 8'h94, 8'h02);
      chk("irq unmasked", {31'h0, irq_o}, 32'h1);
      acc(1'b1, 8'h90, 8'h02);
      acc(1'b1, 8'h84, 8'h8e);
      acc(1'b1, 8'h80, 8'hcc);
      acc(1'b1, 8'h80, 8'h0c);
      acc(1'b0, 8'h80, 8'h00);
      chk("abort", {30'h0, busy_o, rdat[6]}, 32'h0);
      acc(1'b0, 8'h90, 8'h00);
      chk("abort status", rdat, 32'h0);
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
